// File: edge_detect.v
// valid edge detector for one capture or event input, field decoded per 2-bit select
// assumes the input is already synchronous to clk_sys
`timescale 1ns/100ps
`default_nettype none
`include "timer_ctl_map.vh"
module edge_detect
(
  // clock and reset
  input  wire       clk_sys,
  input  wire       reset_n,
  input  wire       clk_en,
  // input and selection
  input  wire       sig_in,
  input  wire [1:0] edge_sel,
  // result
  output reg        edge_hit_r
);
  reg sig_prev_r;

  always @(posedge clk_sys)
  begin
    if (!reset_n)
    begin
      sig_prev_r <= 1'b0;
      edge_hit_r <= 1'b0;
    end
    else if (clk_en)
    begin
      sig_prev_r <= sig_in;
      case (edge_sel)
        `EDGE_RISE: edge_hit_r <= sig_in & ~sig_prev_r;  // [RULE10]
        `EDGE_FALL: edge_hit_r <= ~sig_in & sig_prev_r;  // [RULE10]
        `EDGE_BOTH: edge_hit_r <= sig_in ^ sig_prev_r;   // [RULE10]
        default:    edge_hit_r <= 1'b0;                  // [RULE10]
      endcase
    end
  end
endmodule
`default_nettype wire

// File: timer_ctl_chk.sv
// checker for the timer mode and capture edge control block
// assumes clk_en is high while bus traffic runs
`timescale 1ns/100ps
`default_nettype none
`include "timer_ctl_map.vh"
module timer_ctl_chk
#(
  parameter CNT_W = 16
)
(
  // clock and reset
  input wire logic             clk_sys,
  input wire logic             reset_n,
  input wire logic             clk_en,
  // bus
  input wire logic             wb_cyc_i,
  input wire logic             wb_stb_i,
  input wire logic             wb_we_i,
  input wire logic [7:0]       wb_adr_i,
  input wire logic [3:0]       wb_sel_i,
  input wire logic [31:0]      wb_dat_i,
  input wire logic [31:0]      wb_dat_o,
  input wire logic             wb_ack_o,
  // timer side
  input wire logic [3:0]       capture_in,
  input wire logic [CNT_W-1:0] count_r,
  input wire logic [2:0]       mode_r,
  input wire logic             start_trig_r,
  input wire logic [3:0]       capture_hit_r
);
  default clocking @(posedge clk_sys); endclocking
  default disable iff (!reset_n);
  wire req = wb_cyc_i && wb_stb_i && !wb_ack_o && clk_en;
  property p_ack; req |=> wb_ack_o; endproperty
  a_ack: assert property (p_ack) else $error("request not acked");
  property p_ack_one; wb_ack_o && clk_en |=> !wb_ack_o; endproperty
  a_ack_one: assert property (p_ack_one) else $error("ack too long");
  property p_ack_idle; !(wb_cyc_i && wb_stb_i) && clk_en |=> !wb_ack_o; endproperty
  a_ack_idle: assert property (p_ack_idle) else $error("ack without request");
  property p_dat; !wb_ack_o |-> wb_dat_o == 32'h0; endproperty
  a_dat: assert property (p_dat) else $error("read data outside ack");
  // a step is +1 with wrap, or back to idle on disable
  property p_cnt; $changed(count_r) |-> count_r == $past(count_r) + 16'h1 || count_r == `COUNT_IDLE; endproperty
  a_cnt: assert property (p_cnt) else $error("counter jumped");
  // mode copy shows two edges after the taking edge
  property p_mode;
    req && wb_we_i && wb_sel_i[0] && wb_adr_i == `OFS_MODE_CONTROL |-> ##2 mode_r == $past(wb_dat_i[2:0], 2);
  endproperty
  a_mode: assert property (p_mode) else $error("mode copy wrong");
  property p_trig; start_trig_r |-> (mode_r == `MD_EXT_TRIG_PULSE || mode_r == `MD_ONE_SHOT) ##1 !start_trig_r;
  endproperty
  a_trig: assert property (p_trig) else $error("trigger in wrong mode");
  property p_cap; (capture_hit_r & ~($past(capture_in, 2) ^ $past(capture_in, 3))) == 4'h0; endproperty
  a_cap: assert property (p_cap) else $error("capture hit without edge");
  c_trig: cover property (start_trig_r);
  c_cap: cover property (capture_hit_r != 4'h0);
  c_wrap: cover property (count_r == 16'h0);
endmodule
bind timer_mode_and_capture_edge_control timer_ctl_chk #(.CNT_W(CNT_W)) chk_i (.clk_sys, .reset_n, .clk_en,
  .wb_cyc_i, .wb_stb_i, .wb_we_i, .wb_adr_i, .wb_sel_i, .wb_dat_i, .wb_dat_o, .wb_ack_o,
  .capture_in, .count_r, .mode_r, .start_trig_r, .capture_hit_r);
`default_nettype wire

// File: timer_ctl_map.vh
// register offsets, field positions, reset values and mode and edge encodings for the timer control block
// assumes a 32-bit classic wishbone slave, one register per aligned word
`ifndef TIMER_CTL_MAP_VH
`define TIMER_CTL_MAP_VH

`define OFS_RUN_CONTROL      8'h00
`define OFS_MODE_CONTROL     8'h04
`define OFS_OUTPUT_CONTROL   8'h08
`define OFS_EDGE_SELECT      8'h0C
`define OFS_COUNTER          8'h10

`define RST_REG8             8'h00
`define COUNT_IDLE           16'hFFFF

`define RUN_ENABLE_BIT       7
`define RUN_CKS_MSB          2
`define MODE_SLAVE_BIT       7
`define MODE_SWTRIG_BIT      6
`define MODE_EVENT_BIT       5
`define MODE_MD_MSB          2

`define MD_INTERVAL          3'h0
`define MD_EVENT_COUNT       3'h1
`define MD_EXT_TRIG_PULSE    3'h2
`define MD_ONE_SHOT          3'h3
`define MD_PWM               3'h4
`define MD_FREE_RUN          3'h5
`define MD_PULSE_WIDTH       3'h6
`define MD_TRIANGLE_PWM      3'h7

`define EDGE_NONE            2'h0
`define EDGE_RISE            2'h1
`define EDGE_FALL            2'h2
`define EDGE_BOTH            2'h3

`endif

// File: timer_mode_and_capture_edge_control.v
// mode, count source and capture edge control of a 16-bit timer with a wishbone register file
// assumes synchronous inputs on clk_sys; counter core behaviour beyond counting lives elsewhere
//
// Operation
// [RULE1] 8-bit mode control register, resets to zero, byte or bit access.
// [RULE2] event-count enable low: count on selected internal clock.
// [RULE3] event-count enable high: count once per valid external event edge.
// [RULE4] 3-bit mode field selects one of eight timer modes.
// [RULE5] event count mode always counts external events. The code counts master_count_tick instead while the tuned slave bit is set.
// [RULE6] software changes source and mode only while timer is disabled.
// [RULE7] changes while enabled are undefined; recover by disabling then reprogramming.
// [RULE8] 8-bit output control register, resets to zero, byte or bit access.
// [RULE9] 8-bit capture edge register, four 2-bit fields, bits 7:6 for input 3.
// [RULE10] edge field: 00 none, 01 rising, 10 falling, 11 both.
// [RULE11] counter held at all ones while disabled; reset clears enable. A bus read of the counter returns zero while disabled.
// [RULE12] count source: clock divided by 1 to 128 in powers of two, or events.
// [RULE13] software trigger starts only one-shot and external trigger pulse modes.
// [RULE14] tuned bit makes timer a slave of an external master.
`timescale 1ns/100ps
`default_nettype none
`include "timer_ctl_map.vh"
module timer_mode_and_capture_edge_control
#(
  parameter CNT_W = 16
)
(
  // clock, reset and enable
  input  wire             clk_sys,
  input  wire             reset_n,
  input  wire             clk_en,
  // wishbone slave
  input  wire             wb_cyc_i,
  input  wire             wb_stb_i,
  input  wire             wb_we_i,
  input  wire [7:0]       wb_adr_i,
  input  wire [3:0]       wb_sel_i,
  input  wire [31:0]      wb_dat_i,
  output reg  [31:0]      wb_dat_o,
  output reg              wb_ack_o,
  // pins and master timer link
  input  wire             event_in,
  input  wire [3:0]       capture_in,
  input  wire             master_count_tick,
  // status toward the rest of the timer
  output reg  [CNT_W-1:0] count_r,
  output reg  [2:0]       mode_r,
  output reg              start_trig_r,
  output reg  [3:0]       capture_hit_r,
  output reg  [7:0]       output_control_r
);
  // register state
  reg  [7:0] run_control_r;
  reg  [7:0] timer_mode_control_r;
  reg  [7:0] capture_edge_select_r;
  reg  [6:0] prescale_r;
  reg        tick_r;
  reg        ack_nxt;
  reg [31:0] rd_nxt;
  wire       ev_hit;
  wire [3:0] cap_hit;

  wire       timer_enable       = run_control_r[`RUN_ENABLE_BIT];
  wire [2:0] clock_select       = run_control_r[`RUN_CKS_MSB:0];
  wire       tuned_slave_enable = timer_mode_control_r[`MODE_SLAVE_BIT];
  wire       event_count_enable = timer_mode_control_r[`MODE_EVENT_BIT];
  wire [2:0] mode_field         = timer_mode_control_r[`MODE_MD_MSB:0];

  // merge one byte lane into an 8-bit register on byte enable
  function [7:0] lane_write;
    input [7:0] old_val;
    input [31:0] dat;
    input [3:0] sel;
    begin
      lane_write = sel[0] ? dat[7:0] : old_val;
    end
  endfunction

  wire wr_req = wb_cyc_i & wb_stb_i & wb_we_i & ~wb_ack_o;
  wire rd_req = wb_cyc_i & wb_stb_i & ~wb_we_i & ~wb_ack_o;

  always @*
  begin
    rd_nxt = 32'h00000000;
    case (wb_adr_i)
      `OFS_RUN_CONTROL:    rd_nxt = {24'h000000, run_control_r};
      `OFS_MODE_CONTROL:   rd_nxt = {24'h000000, timer_mode_control_r & 8'hA7};
      `OFS_OUTPUT_CONTROL: rd_nxt = {24'h000000, output_control_r};
      `OFS_EDGE_SELECT:    rd_nxt = {24'h000000, capture_edge_select_r};
      // disabled counter reads zero although it holds all ones
      `OFS_COUNTER:        rd_nxt = timer_enable ? {{(32-CNT_W){1'b0}}, count_r} : 32'h00000000;
      default:             rd_nxt = 32'h00000000;
    endcase
    ack_nxt = wr_req | rd_req;
  end

  // bus side registers
  always @(posedge clk_sys)
  begin
    if (!reset_n)
    begin
      run_control_r         <= `RST_REG8;   // [RULE11]
      timer_mode_control_r  <= `RST_REG8;   // [RULE1]
      output_control_r      <= `RST_REG8;   // [RULE8]
      capture_edge_select_r <= `RST_REG8;   // [RULE9]
      wb_ack_o              <= 1'b0;
      wb_dat_o              <= 32'h00000000;
      start_trig_r          <= 1'b0;
    end
    else if (clk_en)
    begin
      wb_ack_o     <= ack_nxt;
      wb_dat_o     <= rd_req ? rd_nxt : 32'h00000000;
      start_trig_r <= 1'b0;
      if (wr_req)
      begin
        case (wb_adr_i)
          `OFS_RUN_CONTROL:
            run_control_r <= lane_write(run_control_r, wb_dat_i, wb_sel_i) & 8'h87;
          `OFS_MODE_CONTROL:
          begin
            // trigger bit is write-only and never stored
            timer_mode_control_r <= lane_write(timer_mode_control_r, wb_dat_i, wb_sel_i) & 8'hA7;  // [RULE1]
            if (wb_sel_i[0] && wb_dat_i[`MODE_SWTRIG_BIT] && timer_enable &&
                (mode_field == `MD_ONE_SHOT || mode_field == `MD_EXT_TRIG_PULSE))
              start_trig_r <= 1'b1;  // [RULE13]
          end
          `OFS_OUTPUT_CONTROL:
            output_control_r <= lane_write(output_control_r, wb_dat_i, wb_sel_i);  // [RULE8]
          `OFS_EDGE_SELECT:
            capture_edge_select_r <= lane_write(capture_edge_select_r, wb_dat_i, wb_sel_i);  // [RULE9]
          default:
            run_control_r <= run_control_r;
        endcase
      end
    end
  end

  // event input shares the channel 0 edge field
  edge_detect u_event
  (
    .clk_sys    (clk_sys),
    .reset_n    (reset_n),
    .clk_en     (clk_en),
    .sig_in     (event_in),
    .edge_sel   (capture_edge_select_r[1:0]),
    .edge_hit_r (ev_hit)
  );

  genvar ch;
  generate
    for (ch = 0; ch < 4; ch = ch + 1)
    begin : g_cap
      edge_detect u_cap
      (
        .clk_sys    (clk_sys),
        .reset_n    (reset_n),
        .clk_en     (clk_en),
        .sig_in     (capture_in[ch]),
        .edge_sel   (capture_edge_select_r[2*ch+1:2*ch]),  // [RULE9]
        .edge_hit_r (cap_hit[ch])
      );
    end
  endgenerate

  // prescaler; counting from a divided tap keeps one tick per period
  always @(posedge clk_sys)
  begin
    if (!reset_n)
    begin
      prescale_r <= 7'h00;
      tick_r     <= 1'b0;
    end
    else if (clk_en)
    begin
      if (!timer_enable)
        prescale_r <= 7'h00;
      else
        prescale_r <= prescale_r + 7'h01;
      case (clock_select)
        3'h0:    tick_r <= timer_enable;                                  // [RULE12]
        3'h1:    tick_r <= timer_enable & (prescale_r[0:0] == 1'h1);
        3'h2:    tick_r <= timer_enable & (prescale_r[1:0] == 2'h3);
        3'h3:    tick_r <= timer_enable & (prescale_r[2:0] == 3'h7);
        3'h4:    tick_r <= timer_enable & (prescale_r[3:0] == 4'hF);
        3'h5:    tick_r <= timer_enable & (prescale_r[4:0] == 5'h1F);
        3'h6:    tick_r <= timer_enable & (prescale_r[5:0] == 6'h3F);
        default: tick_r <= timer_enable & (prescale_r[6:0] == 7'h7F);   // [RULE12]
      endcase
    end
  end

  // count source selection; mode and source assumed stable while enabled [RULE6] [RULE7]
  reg count_step;
  always @*
  begin
    if (tuned_slave_enable)
      count_step = master_count_tick;                       // [RULE14]
    else if (mode_field == `MD_EVENT_COUNT || event_count_enable)
      count_step = ev_hit;                                  // [RULE3] [RULE5]
    else
      count_step = tick_r;                                  // [RULE2]
  end

  always @(posedge clk_sys)
  begin
    if (!reset_n)
    begin
      count_r       <= `COUNT_IDLE;
      mode_r        <= `MD_INTERVAL;
      capture_hit_r <= 4'h0;
    end
    else if (clk_en)
    begin
      mode_r        <= mode_field;                           // [RULE4]
      capture_hit_r <= timer_enable ? cap_hit : 4'h0;
      if (!timer_enable)
        count_r <= `COUNT_IDLE;                              // [RULE11]
      else if (count_step)
        count_r <= count_r + {{(CNT_W-1){1'b0}}, 1'b1};      // wraps from all ones to zero first
    end
  end
endmodule
`default_nettype wire

// File: timer_mode_and_capture_edge_control_tb_top.sv
// bench for the timer control block: wishbone register tests and count sources
// assumes clk_en held high throughout
`timescale 1ns/100ps
`default_nettype none
`include "timer_ctl_map.vh"
module timer_mode_and_capture_edge_control_tb_top;
  logic        clk_sys = 1'h0, reset_n = 1'h0, clk_en = 1'h1, event_in = 1'h0, master_count_tick = 1'h0;
  logic        wb_cyc_i = 1'h0, wb_stb_i = 1'h0, wb_we_i = 1'h0;
  logic [7:0]  wb_adr_i = 8'h0;
  logic [3:0]  wb_sel_i = 4'h0, capture_in = 4'h0;
  logic [31:0] wb_dat_i = 32'h0;
  wire  [31:0] wb_dat_o;
  wire         wb_ack_o, start_trig_r;
  wire  [15:0] count_r;
  wire  [2:0]  mode_r;
  wire  [3:0]  capture_hit_r;
  wire  [7:0]  output_control_r;
  int          num_errors = 0, checked = 0, cycles = 0, trigs = 0, t0;
  int          hit[4];
  int          exp_h[4] = '{1, 1, 0, 2};
  timer_mode_and_capture_edge_control timer_mode_and_capture_edge_control_i (.clk_sys, .reset_n, .clk_en,
    .wb_cyc_i, .wb_stb_i, .wb_we_i, .wb_adr_i, .wb_sel_i, .wb_dat_i, .wb_dat_o, .wb_ack_o, .event_in,
    .capture_in, .master_count_tick, .count_r, .mode_r, .start_trig_r, .capture_hit_r, .output_control_r);
  always #5 clk_sys = ~clk_sys;
  always @(posedge clk_sys)
  begin
    cycles++;
    trigs += (start_trig_r === 1'h1);
    for (int i = 0; i < 4; i++)
      hit[i] += (capture_hit_r[i] === 1'h1);
    // ceiling well above the roughly 1400 cycles the tests need
    if (cycles == 20000)
    begin
      num_errors++;
      test_done;
    end
  end
  task automatic test_done;
    $display("checked=%0d num_errors=%0d", checked, num_errors);
    if (num_errors == 0 && checked > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    checked++;
    if (got !== exp)
    begin
      num_errors++;
      $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] d, input logic [3:0] s,
                    output logic [31:0] q);
    int n;
    n = 0;
    @(posedge clk_sys);
    wb_cyc_i <= 1'h1;
    wb_stb_i <= 1'h1;
    wb_we_i <= w;
    wb_adr_i <= a;
    wb_dat_i <= d;
    wb_sel_i <= s;
    do @(posedge clk_sys); while (wb_ack_o !== 1'h1 && ++n < 50);
    q = wb_dat_o;
    if (n >= 50)
    begin
      num_errors++;
      test_done;
    end
    wb_cyc_i <= 1'h0;
    wb_stb_i <= 1'h0;
  endtask
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    logic [31:0] q;
    wb(1'h1, a, {24'h0, d}, 4'h1, q);
  endtask
  task automatic rd(input logic [7:0] a, input logic [31:0] e);
    logic [31:0] q;
    wb(1'h0, a, 32'h0, 4'hF, q);
    chk(q, e);
  endtask
  task automatic run(input logic [7:0] md);
    wr(`OFS_RUN_CONTROL, 8'h00);
    wr(`OFS_MODE_CONTROL, md);
    wr(`OFS_RUN_CONTROL, 8'h80);
  endtask
  task automatic pulses(input int n, input bit tick);
    repeat (n)
    begin
      @(posedge clk_sys);
      if (tick)
        master_count_tick <= 1'h1;
      else
        event_in <= 1'h1;
      @(posedge clk_sys);
      master_count_tick <= 1'h0;
      event_in <= 1'h0;
      repeat (3) @(posedge clk_sys);
    end
  endtask
  task automatic count_src(input logic [7:0] md, input int n, input bit tick);
    run(md);
    chk(count_r, 32'hFFFF);
    pulses(n, tick);
    chk(16'(count_r - 16'hFFFF), n);
  endtask
  initial
  begin
    logic [31:0] q;
    logic [15:0] c0;
    repeat (8) @(posedge clk_sys);
    reset_n <= 1'h1;
    for (int a = 0; a < 24; a += 4)
      rd(8'(a), 32'h0);
    wr(`OFS_MODE_CONTROL, 8'hFF);
    rd(`OFS_MODE_CONTROL, 32'hA7);
    wr(`OFS_OUTPUT_CONTROL, 8'h5A);
    wb(1'h1, `OFS_OUTPUT_CONTROL, 32'hFF, 4'h0, q);
    rd(`OFS_OUTPUT_CONTROL, 32'h5A);
    chk(output_control_r, 32'h5A);
    wr(8'h14, 8'hFF);
    rd(8'h14, 32'h0);
    wr(`OFS_EDGE_SELECT, 8'hC6);
    rd(`OFS_EDGE_SELECT, 32'hC6);
    for (int m = 0; m < 8; m++)
    begin
      t0 = trigs;
      run(8'(m));
      wr(`OFS_MODE_CONTROL, 8'(m) | 8'h40);
      repeat (3) @(posedge clk_sys);
      chk(trigs - t0, (m == 2 || m == 3));
      rd(`OFS_MODE_CONTROL, m);
      chk(mode_r, m);
    end
    hit = '{default: 0};
    capture_in <= 4'hF;
    repeat (5) @(posedge clk_sys);
    capture_in <= 4'h0;
    repeat (5) @(posedge clk_sys);
    for (int i = 0; i < 4; i++)
      chk(hit[i], exp_h[i]);
    // stop first: mode may only change while disabled
    wr(`OFS_RUN_CONTROL, 8'h00);
    wr(`OFS_MODE_CONTROL, 8'h05);
    // clock select may only change with the timer stopped
    for (int k = 0; k < 8; k++)
    begin
      wr(`OFS_RUN_CONTROL, 8'(k));
      wr(`OFS_RUN_CONTROL, 8'(k) | 8'h80);
      repeat (4) @(posedge clk_sys);
      c0 = count_r;
      repeat (128) @(posedge clk_sys);
      chk(16'(count_r - c0), 128 >> k);
    end
    wr(`OFS_EDGE_SELECT, 8'h01);
    count_src(8'h25, 5, 1'h0);
    count_src(8'h01, 3, 1'h0);
    count_src(8'h85, 4, 1'h1);
    test_done;
  end
endmodule
`default_nettype wire
